// ### rtl/ocdcu_cnt.v
// byte counter for memory transfers, zero size means 65536
`timescale 1ns/1ps
module ocdcu_cnt
(
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // control
  input wire load_i,
  input wire [15:0] size_i,
  input wire dec_i,
  // state
  output wire last_o
);
  reg [16:0] left_r;
  reg [16:0] left_nxt;
  always @*
  begin
    left_nxt = left_r;
    if (load_i)
      left_nxt = (size_i == 16'h0000) ? 17'h10000 : {1'b0, size_i};
    else if (dec_i)
      left_nxt = left_r - 17'h00001;
  end
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      left_r <= 17'h00000;
    else
      left_r <= left_nxt;
  end
  assign last_o = (left_r == 17'h00001);
endmodule

// ### rtl/ocdcu_defs.vh
// constants for the on-chip debug command unit
`ifndef OCDCU_DEFS_VH
`define OCDCU_DEFS_VH
`define OCDCU_OP_BREAK 8'h00
`define OCDCU_CMD_RD_REV 8'h00
`define OCDCU_CMD_RD_STAT 8'h02
`define OCDCU_CMD_RD_RTC 8'h03
`define OCDCU_CMD_WR_CTL 8'h04
`define OCDCU_CMD_RD_CTL 8'h05
`define OCDCU_CMD_WR_PMEM 8'h0a
`define OCDCU_CMD_RD_PMEM 8'h0b
`define OCDCU_CMD_WR_DMEM 8'h0c
`define OCDCU_CMD_RD_DMEM 8'h0d
`define OCDCU_BLANK_BYTE 8'hff
`define OCDCU_CTL_DBG_BIT 7
`define OCDCU_STAT_DBG_BIT 7
`define OCDCU_STAT_HALT_BIT 6
`define OCDCU_STAT_RP_BIT 5
`define OCDCU_CTL_RST 8'h00
`define OCDCU_REV_VALUE 16'h0101
`endif

// ### rtl/ocdcu_top.v
// command interpreter of the on-chip debug unit
//
// Contract
// - returning to a break instruction previously looped on sets debug mode.
// - no command waits for the cpu to stop; cpu_stopped_i only feeds the status byte.
// - the break instruction is decoded from opcode 00h.
// - outside debug mode only a subset is accepted, all inside unless guarded.
// - 00h, 02h, 04h, 05h work always, 03h only in debug mode.
// - under read protection write control cannot clear the debug flag.
// - 0ah takes address, size and data bytes into program memory.
// - a size field of zero means 65536 bytes.
// - program writes are dropped unless the flash is unlocked.
// - memory writes are dropped outside debug mode or under read protection.
// - 0bh returns program bytes, or ffh outside debug or when protected.
// - 0ch stores data bytes into data memory at consecutive addresses.
// - 0dh returns data bytes, ffh only outside debug mode.
`timescale 1ns/1ps
`include "ocdcu_defs.vh"
module ocdcu_top
(
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // host byte stream from the serial debug interface
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  output wire tx_valid_o,
  output wire [7:0] tx_data_o,
  input wire tx_ready_i,
  // cpu status
  input wire cpu_fetch_i,
  input wire [15:0] cpu_pc_i,
  input wire [7:0] cpu_opcode_i,
  input wire cpu_stopped_i,
  input wire read_protect_option_i,
  input wire flash_unlocked_i,
  input wire [15:0] runtime_cnt_i,
  // debug state
  output wire debug_mode_flag_o,
  output wire [7:0] ctl_o,
  // memory port
  output wire mem_wr_o,
  output wire mem_rd_o,
  output wire mem_prog_o,
  output wire [15:0] mem_addr_o,
  output wire [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i
);
  localparam S_CMD = 3'h0;
  localparam S_AH = 3'h1;
  localparam S_AL = 3'h2;
  localparam S_SH = 3'h3;
  localparam S_SL = 3'h4;
  localparam S_DATA = 3'h5;
  localparam S_TX = 3'h6;
  localparam S_WCTL = 3'h7;

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [7:0] cmd_r;
  reg [15:0] addr_r;
  reg [7:0] size_hi_r;
  reg [7:0] ctl_r;
  reg [7:0] tx_r;
  reg txv_r;
  reg [1:0] nleft_r;
  reg brk_loop_r;
  reg [15:0] brk_pc_r;
  reg wr_r;
  reg rd_r;
  reg [7:0] wd_r;
  wire last;
  wire cnt_load;
  wire cnt_dec;
  wire is_wr;
  wire is_prog;
  wire dbg;
  wire brk_fetch;
  reg [7:0] reply;
  localparam [15:0] REV_WORD = `OCDCU_REV_VALUE;

  assign dbg = ctl_r[`OCDCU_CTL_DBG_BIT];
  assign is_wr = ~cmd_r[0];
  assign is_prog = (cmd_r[3:0] == 4'ha) || (cmd_r[3:0] == 4'hb);
  assign brk_fetch = cpu_fetch_i && (cpu_opcode_i == `OCDCU_OP_BREAK);

  ocdcu_cnt u_cnt
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(cnt_load),
    .size_i({size_hi_r, rx_data_i}),
    .dec_i(cnt_dec),
    .last_o(last)
  );
  assign cnt_load = (st_r == S_SL) && rx_valid_i;
  assign cnt_dec = (st_r == S_DATA) &&
    (is_wr ? rx_valid_i : (txv_r && tx_ready_i));

  ////////////////////////////////////////////////////////////////////////
  // reply byte for single replies and memory reads
  always @*
  begin
    reply = `OCDCU_BLANK_BYTE;
    case (cmd_r)
      `OCDCU_CMD_RD_REV:
        reply = (nleft_r == 2'h2) ? REV_WORD[15:8] : REV_WORD[7:0];
      `OCDCU_CMD_RD_STAT:
        reply = {dbg, cpu_stopped_i, read_protect_option_i, 5'h00};
      `OCDCU_CMD_RD_RTC:
        reply = (nleft_r == 2'h2) ? runtime_cnt_i[15:8] : runtime_cnt_i[7:0];
      `OCDCU_CMD_RD_CTL:
        reply = ctl_r;
      `OCDCU_CMD_RD_PMEM:
        reply = (dbg && !read_protect_option_i) ? mem_rdata_i :
          `OCDCU_BLANK_BYTE;
      `OCDCU_CMD_RD_DMEM:
        reply = dbg ? mem_rdata_i : `OCDCU_BLANK_BYTE;
      default:
        reply = `OCDCU_BLANK_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // command decoder
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_CMD:
        if (rx_valid_i)
        begin
          case (rx_data_i)
            `OCDCU_CMD_RD_REV, `OCDCU_CMD_RD_STAT, `OCDCU_CMD_RD_CTL:
              st_nxt = S_TX;
            `OCDCU_CMD_RD_RTC:
              st_nxt = dbg ? S_TX : S_CMD;
            `OCDCU_CMD_WR_CTL:
              st_nxt = S_WCTL;
            `OCDCU_CMD_WR_PMEM, `OCDCU_CMD_RD_PMEM,
            `OCDCU_CMD_WR_DMEM, `OCDCU_CMD_RD_DMEM:
              st_nxt = S_AH;
            default:
              st_nxt = S_CMD;
          endcase
        end
      S_AH:
        if (rx_valid_i)
          st_nxt = S_AL;
      S_AL:
        if (rx_valid_i)
          st_nxt = S_SH;
      S_SH:
        if (rx_valid_i)
          st_nxt = S_SL;
      S_SL:
        if (rx_valid_i)
          st_nxt = S_DATA;
      S_DATA:
        if (cnt_dec && last)
          st_nxt = S_CMD;
      S_TX:
        if (txv_r && tx_ready_i && nleft_r == 2'h1)
          st_nxt = S_CMD;
      S_WCTL:
        if (rx_valid_i)
          st_nxt = S_CMD;
      default:
        st_nxt = S_CMD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequential state
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= S_CMD;
      cmd_r <= 8'h00;
      addr_r <= 16'h0000;
      size_hi_r <= 8'h00;
      ctl_r <= `OCDCU_CTL_RST;
      tx_r <= 8'h00;
      txv_r <= 1'b0;
      nleft_r <= 2'h0;
      brk_loop_r <= 1'b0;
      brk_pc_r <= 16'h0000;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      wd_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      if (st_r == S_CMD && rx_valid_i)
      begin
        cmd_r <= rx_data_i;
        nleft_r <= (rx_data_i == `OCDCU_CMD_RD_REV ||
          rx_data_i == `OCDCU_CMD_RD_RTC) ? 2'h2 : 2'h1;
      end
      if (st_r == S_AH && rx_valid_i)
        addr_r[15:8] <= rx_data_i;
      if (st_r == S_AL && rx_valid_i)
        addr_r[7:0] <= rx_data_i;
      if (st_r == S_SH && rx_valid_i)
        size_hi_r <= rx_data_i;
      // reads: request memory, then offer the byte on the next cycle
      if ((st_r == S_SL && rx_valid_i && !is_wr) ||
        (st_r == S_DATA && !is_wr && cnt_dec && !last))
        rd_r <= 1'b1;
      if (rd_r)
      begin
        tx_r <= reply;
        txv_r <= 1'b1;
      end
      else if (st_r == S_TX && !txv_r)
      begin
        tx_r <= reply;
        txv_r <= 1'b1;
      end
      else if (txv_r && tx_ready_i)
      begin
        txv_r <= 1'b0;
        if (st_r == S_TX)
          nleft_r <= nleft_r - 2'h1;
      end
      if (st_r == S_DATA && cnt_dec)
        addr_r <= addr_r + 16'h0001;
      if (st_r == S_DATA && is_wr && rx_valid_i)
      begin
        wd_r <= rx_data_i;
        wr_r <= dbg && !read_protect_option_i &&
          (!is_prog || flash_unlocked_i);
      end
      if (st_r == S_WCTL && rx_valid_i)
      begin
        ctl_r <= rx_data_i;
        if (read_protect_option_i && dbg)
          ctl_r[`OCDCU_CTL_DBG_BIT] <= 1'b1;
      end
      // remember the break loop, enter debug mode on return to it
      if (brk_fetch && !dbg)
      begin
        if (brk_loop_r && cpu_pc_i == brk_pc_r)
          ctl_r[`OCDCU_CTL_DBG_BIT] <= 1'b1;
        else
        begin
          brk_loop_r <= 1'b1;
          brk_pc_r <= cpu_pc_i;
        end
      end
      if (dbg)
        brk_loop_r <= 1'b0;
    end
  end

  assign tx_valid_o = txv_r;
  assign tx_data_o = tx_r;
  assign debug_mode_flag_o = dbg;
  assign ctl_o = ctl_r;
  assign mem_wr_o = wr_r;
  assign mem_rd_o = rd_r;
  assign mem_prog_o = is_prog;
  assign mem_addr_o = wr_r ? addr_r - 16'h0001 : addr_r;
  assign mem_wdata_o = wd_r;
endmodule

// ### verification/ocdcu_chk.sv
// port assertions for the debug command unit
`timescale 1ns/1ps
module ocdcu_chk
(
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // host stream and levels
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire tx_ready_i,
  input wire read_protect_option_i,
  input wire flash_unlocked_i,
  // cpu fetch
  input wire cpu_fetch_i,
  input wire [7:0] cpu_opcode_i,
  // debug state and memory port
  input wire debug_mode_flag_o,
  input wire [7:0] ctl_o,
  input wire mem_wr_o,
  input wire mem_rd_o,
  input wire mem_prog_o,
  input wire [7:0] mem_wdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_WR_GATE:
    assert property (mem_wr_o |-> debug_mode_flag_o && !read_protect_option_i)
    else $error("write outside debug or protected");
  AST_PWR_UNLK:
    assert property (mem_wr_o && mem_prog_o |-> flash_unlocked_i)
    else $error("program write while locked");
  AST_WR_DATA:
    assert property (mem_wr_o |-> $past(rx_valid_i) &&
      mem_wdata_o == $past(rx_data_i))
    else $error("write data not last host byte");
  AST_RP_KEEP:
    assert property (read_protect_option_i && debug_mode_flag_o
      |=> debug_mode_flag_o)
    else $error("debug flag cleared under protection");
  AST_CTL_MIRROR:
    assert property (debug_mode_flag_o == ctl_o[7])
    else $error("flag differs from control bit");
  AST_BRK_ENTRY:
    assert property ($rose(debug_mode_flag_o) |-> $past(rx_valid_i) ||
      ($past(cpu_fetch_i) && $past(cpu_opcode_i) == 8'h00))
    else $error("debug flag set without break return");
  AST_TX_HOLD:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
      $stable(tx_data_o))
    else $error("reply dropped before accept");
  AST_RD_REPLY:
    assert property (mem_rd_o |=> tx_valid_o)
    else $error("no reply after memory read");
  AST_RW_EXCL:
    assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write together");
endmodule

// ### verification/ocdcu_mem.sv
// program and data memory seen from the debug unit
`timescale 1ns/1ps
module ocdcu_mem
(
  // clock
  input wire ref_clk_i,
  // memory port
  input wire mem_wr_i,
  input wire mem_rd_i,
  input wire mem_prog_i,
  input wire [15:0] mem_addr_i,
  input wire [7:0] mem_wdata_i,
  output wire [7:0] mem_rdata_o
);
  reg [7:0] m [0:511];
  reg [7:0] last;
  reg rd_d;
  integer i;
  wire [8:0] idx = {mem_prog_i, mem_addr_i[7:0]};
  // data only stands around a read, else a changing pattern
  assign mem_rdata_o = (mem_rd_i | rd_d) ? m[idx] : ~last;
  initial
  begin
    rd_d = 1'b0;
    last = 8'h00;
    for (i = 0; i < 512; i = i + 1)
      m[i] = 8'h3c;
  end
  always @(posedge ref_clk_i)
  begin
    rd_d <= mem_rd_i;
    last <= mem_rdata_o;
    if (mem_wr_i)
      m[idx] <= mem_prog_i ? (m[idx] & mem_wdata_i) : mem_wdata_i;
  end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the debug command unit
`timescale 1ns/1ps
`include "ocdcu_defs.vh"
module tb_top;
  reg ref_clk_i, rst_b_i, rx_valid_i, tx_ready_i, cpu_fetch_i;
  reg cpu_stopped_i, read_protect_option_i, flash_unlocked_i;
  reg [7:0] rx_data_i, cpu_opcode_i;
  reg [15:0] cpu_pc_i, runtime_cnt_i;
  wire tx_valid_o, debug_mode_flag_o, mem_wr_o, mem_rd_o, mem_prog_o;
  wire [7:0] tx_data_o, ctl_o, mem_wdata_o, mem_rdata_i;
  wire [15:0] mem_addr_o;
  integer miscompares = 0, checks = 0, cyc = 0;
  localparam [15:0] REV_WORD = `OCDCU_REV_VALUE;
  ocdcu_top i_dut (.*);
  ocdcu_mem i_mem (.ref_clk_i(ref_clk_i), .mem_wr_i(mem_wr_o),
    .mem_rd_i(mem_rd_o), .mem_prog_i(mem_prog_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  //////////////////////////////////////////////////////////////////////////
  task end_sim;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input string nm, input [7:0] exp, input [7:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task send(input [7:0] b);
  begin
    @(negedge ref_clk_i);
    rx_valid_i = 1'b1;
    rx_data_i = b;
    @(negedge ref_clk_i);
    rx_valid_i = 1'b0;
  end
  endtask
  task hdr(input [7:0] c, input [15:0] a, input [15:0] s);
  begin
    send(c);
    send(a[15:8]);
    send(a[7:0]);
    send(s[15:8]);
    send(s[7:0]);
  end
  endtask
  // wait for a reply byte, judge it, then accept it
  task get(input string nm, input [7:0] exp);
    integer n;
  begin
    n = 0;
    while (tx_valid_o !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk_i);
      n = n + 1;
    end
    chk({nm, " valid"}, 8'h01, {7'h00, tx_valid_o});
    chk(nm, exp, tx_data_o);
    tx_ready_i = 1'b1;
    @(negedge ref_clk_i);
    tx_ready_i = 1'b0;
  end
  endtask
  task fetch(input [7:0] op);
  begin
    @(negedge ref_clk_i);
    cpu_fetch_i = 1'b1;
    cpu_opcode_i = op;
    @(negedge ref_clk_i);
    cpu_fetch_i = 1'b0;
  end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_normal;
  begin
    send(`OCDCU_CMD_RD_REV);
    get("rev hi", REV_WORD[15:8]);
    get("rev lo", REV_WORD[7:0]);
    send(`OCDCU_CMD_RD_STAT);
    get("status", 8'h00);
    hdr(`OCDCU_CMD_RD_DMEM, 16'h0010, 16'h0001);
    get("dmem idle", 8'hff);
    hdr(`OCDCU_CMD_RD_PMEM, 16'h0010, 16'h0001);
    get("pmem idle", 8'hff);
    hdr(`OCDCU_CMD_WR_DMEM, 16'h0010, 16'h0001);
    send(8'h55);
    send(`OCDCU_CMD_RD_RTC);
    repeat (6) @(negedge ref_clk_i);
    chk("rtc quiet", 8'h00, {7'h00, tx_valid_o});
    $display("test normal done");
  end
  endtask
  task t_break;
  begin
    cpu_stopped_i = 1'b1;
    repeat (2) fetch(8'hff);
    chk("flag plain", 8'h00, {7'h00, debug_mode_flag_o});
    repeat (2) fetch(`OCDCU_OP_BREAK);
    repeat (2) @(negedge ref_clk_i);
    chk("flag brk", 8'h01, {7'h00, debug_mode_flag_o});
    send(`OCDCU_CMD_RD_CTL);
    get("ctl", 8'h80);
    send(`OCDCU_CMD_RD_STAT);
    get("status dbg", 8'hc0);
    $display("test break done");
  end
  endtask
  task t_mem;
  begin
    hdr(`OCDCU_CMD_RD_DMEM, 16'h0010, 16'h0001);
    get("dropped", 8'h3c);
    hdr(`OCDCU_CMD_WR_DMEM, 16'h0010, 16'h0002);
    send(8'h55);
    send(8'haa);
    hdr(`OCDCU_CMD_RD_DMEM, 16'h0010, 16'h0002);
    get("dmem 0", 8'h55);
    get("dmem 1", 8'haa);
    hdr(`OCDCU_CMD_WR_PMEM, 16'h0020, 16'h0001);
    send(8'h11);
    flash_unlocked_i = 1'b1;
    hdr(`OCDCU_CMD_WR_PMEM, 16'h0021, 16'h0001);
    send(8'h14);
    hdr(`OCDCU_CMD_RD_PMEM, 16'h0020, 16'h0002);
    get("pmem lock", 8'h3c);
    get("pmem open", 8'h14);
    hdr(`OCDCU_CMD_WR_PMEM, 16'h0021, 16'h0001);
    send(`OCDCU_OP_BREAK);
    hdr(`OCDCU_CMD_WR_PMEM, 16'h0021, 16'h0001);
    send(8'h14);
    hdr(`OCDCU_CMD_RD_PMEM, 16'h0021, 16'h0001);
    get("brk kept", `OCDCU_OP_BREAK);
    send(`OCDCU_CMD_RD_RTC);
    get("rtc hi", 8'h12);
    get("rtc lo", 8'h34);
    $display("test memory done");
  end
  endtask
  task t_prot;
  begin
    read_protect_option_i = 1'b1;
    send(`OCDCU_CMD_RD_STAT);
    get("status prot", 8'he0);
    hdr(`OCDCU_CMD_RD_PMEM, 16'h0021, 16'h0001);
    get("pmem prot", 8'hff);
    hdr(`OCDCU_CMD_WR_DMEM, 16'h0011, 16'h0001);
    send(8'h77);
    hdr(`OCDCU_CMD_RD_DMEM, 16'h0011, 16'h0001);
    get("dmem prot", 8'haa);
    send(`OCDCU_CMD_WR_CTL);
    send(8'h00);
    repeat (3) @(negedge ref_clk_i);
    chk("flag kept", 8'h80, ctl_o);
    read_protect_option_i = 1'b0;
    send(`OCDCU_CMD_WR_CTL);
    send(8'h00);
    repeat (3) @(negedge ref_clk_i);
    chk("flag clear", 8'h00, ctl_o);
    $display("test protect done");
  end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial
  begin
    {rx_valid_i, tx_ready_i, cpu_fetch_i, cpu_stopped_i} = 4'h0;
    {read_protect_option_i, flash_unlocked_i, rst_b_i} = 3'h0;
    rx_data_i = 8'h00;
    cpu_opcode_i = 8'h00;
    cpu_pc_i = 16'h0100;
    runtime_cnt_i = 16'h1234;
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_normal;
    t_break;
    t_mem;
    t_prot;
    end_sim;
  end
endmodule
bind ocdcu_top ocdcu_chk u_chk (.*);
